// file: common/p9gm_defines.vh
/*
 * Constants of the five-pin general-purpose port with LCD supply-pin hand-over.
 * Assumes inclusion by bare name from the design file; holds definitions only.
 */
// How it works
// - Direction one makes the pin an output
// - Output pin drives the data latch bit
// - Data write updates latch, outputs follow directly
// - Output pins read back the latch
// - Direction zero makes input, driver off
// - Input pins: latch updates, not driven
// - Input pins read the sampled pin level
// - Read-modify-write reads return latch always
// - Select bit zero keeps general-purpose function
// - Reset clears all direction bits
// - Standby with control set forces high impedance
// - Forced standby clamps inputs to low
// - Control clear leaves pins unchanged in standby
// - Select bit one hands pin to LCD
// - Bits zero to four map pins
`ifndef P9GM_DEFINES_VH
`define P9GM_DEFINES_VH
// Register offsets on the plain register port.
`define P9GM_OFS_DATA   8'h00
`define P9GM_OFS_DIR    8'h01
`define P9GM_OFS_CFG    8'h02
`define P9GM_OFS_STAT   8'h03
// Field positions.
`define P9GM_PINS       5
`define P9GM_CFG_SPL    7
`define P9GM_STAT_HIZ   0
// Reset values.
`define P9GM_RST_PINS   5'h00
`define P9GM_RST_BYTE   8'h00
`endif

// file: verilog/p9gm_port.v
/*
 * Five-pin general-purpose I/O port with per-pin data latch and direction,
 * per-pin hand-over to the LCD drive supply, and standby pin forcing.
 * Assumes one 125 MHz clock, a synchronous active-high reset, a register
 * master on the same clock, and pins that arrive asynchronously.
 */
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "p9gm_defines.vh"

module p9gm_port (
	input  wire       core_clk,
	input  wire       reset,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire       reg_rmw,
	output reg  [7:0] reg_rdata,
	input  wire       standby_mode,
	input  wire [4:0] pin_in,
	output reg  [4:0] pin_out,
	output reg  [4:0] pin_oe,
	output reg  [4:0] lcd_supply_en,
	output reg        pins_forced_hiz
);

	// Widens a five-bit pin vector to a byte; upper bits read as zero.
	function [7:0] p9gm_widen;
		input [4:0] v;
		begin
			p9gm_widen = {3'h0, v};
		end
	endfunction

	// Software-visible state.
	reg  [4:0] port9_data_latch_q;      // Output latch.
	reg  [4:0] port9_direction_q;       // One marks an output pin.
	reg  [4:0] lcd_supply_pin_select_q; // One hands the pin to the LCD supply.
	reg        standby_pin_state_ctrl_q; // Standby forcing enable.
	// Pin synchroniser stages.
	reg  [4:0] pin_meta_q;              // First stage, read only by the second.
	reg  [4:0] pin_sync_q;              // Second stage, safe to read.
	// Standby tracking.
	reg        standby_prev_q;          // Standby level one cycle ago.
	reg        hiz_q;                   // Pins held at high impedance.
	reg        hiz_d;                   // Next value of the forcing flag.
	// Derived values.
	wire [4:0] in_val;                  // Internal input value after clamping.
	wire [4:0] rd_data_pins;            // Value a data read returns.
	reg  [7:0] rdata_d;                 // Next read data.
	wire       wr_data;                 // Write to the data latch.
	wire       wr_dir;                  // Write to the direction register.
	wire       wr_cfg;                  // Write to the configuration register.
	wire [4:0] dir_next;                // Direction as it stands after this edge.
	wire [4:0] sel_next;                // Supply select as it stands after this edge.

	assign wr_data = reg_wr && (reg_addr == `P9GM_OFS_DATA);
	assign wr_dir  = reg_wr && (reg_addr == `P9GM_OFS_DIR);
	assign wr_cfg  = reg_wr && (reg_addr == `P9GM_OFS_CFG);

	// Next register values, so that the driven outputs change at the write edge itself.
	assign dir_next = wr_dir ? reg_wdata[4:0] : port9_direction_q;
	assign sel_next = wr_cfg ? reg_wdata[4:0] : lcd_supply_pin_select_q;

	// Two flip-flops bring the pin levels into the clock domain.
	always @(posedge core_clk) begin
		if (reset) begin
			pin_meta_q <= `P9GM_RST_PINS;
			pin_sync_q <= `P9GM_RST_PINS;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// A forced standby blocks the input path and holds it low.
	assign in_val = hiz_q ? `P9GM_RST_PINS : pin_sync_q;

	// Data reads pick latch or pin per bit; a read-modify-write takes the latch.
	genvar gi;
	generate
		for (gi = 0; gi < `P9GM_PINS; gi = gi + 1) begin : g_rd
			assign rd_data_pins[gi] = (reg_rmw || port9_direction_q[gi]) ?
				port9_data_latch_q[gi] : in_val[gi];
		end
	endgenerate

	// Registers written by software; latch is written regardless of direction.
	always @(posedge core_clk) begin
		if (reset) begin
			port9_data_latch_q       <= `P9GM_RST_PINS;
			port9_direction_q        <= `P9GM_RST_PINS;
			lcd_supply_pin_select_q  <= `P9GM_RST_PINS;
			standby_pin_state_ctrl_q <= 1'b0;
		end else begin
			if (wr_data) begin
				port9_data_latch_q <= reg_wdata[4:0];
			end
			if (wr_dir) begin
				port9_direction_q <= reg_wdata[4:0];
			end
			if (wr_cfg) begin
				lcd_supply_pin_select_q  <= reg_wdata[4:0];
				standby_pin_state_ctrl_q <= reg_wdata[`P9GM_CFG_SPL];
			end
		end
	end

	// Standby forcing is decided at entry and released when standby ends.
	always @* begin
		hiz_d = hiz_q;
		if (!standby_mode) begin
			hiz_d = 1'b0;
		end else if (!standby_prev_q) begin
			hiz_d = standby_pin_state_ctrl_q;
		end
	end

	// Standby state registers.
	always @(posedge core_clk) begin
		if (reset) begin
			standby_prev_q <= 1'b0;
			hiz_q          <= 1'b0;
		end else begin
			standby_prev_q <= standby_mode;
			hiz_q          <= hiz_d;
		end
	end

	// Read data is selected by address and shown in the next cycle only.
	always @* begin
		rdata_d = `P9GM_RST_BYTE;
		if (reg_rd) begin
			case (reg_addr)
				`P9GM_OFS_DATA: begin
					rdata_d = p9gm_widen(rd_data_pins);
				end
				`P9GM_OFS_DIR: begin
					rdata_d = p9gm_widen(port9_direction_q);
				end
				`P9GM_OFS_CFG: begin
					rdata_d = {standby_pin_state_ctrl_q, 2'h0, lcd_supply_pin_select_q};
				end
				`P9GM_OFS_STAT: begin
					rdata_d = {7'h00, hiz_q};
				end
				default: begin
					rdata_d = `P9GM_RST_BYTE;
				end
			endcase
		end
	end

	// Pin drive, LCD hand-over and read data all leave from flip-flops.
	always @(posedge core_clk) begin
		if (reset) begin
			pin_out         <= `P9GM_RST_PINS;
			pin_oe          <= `P9GM_RST_PINS;
			lcd_supply_en   <= `P9GM_RST_PINS;
			pins_forced_hiz <= 1'b0;
			reg_rdata       <= `P9GM_RST_BYTE;
		end else begin
			// Output drives the latch even while the driver is off.
			pin_out <= wr_data ? reg_wdata[4:0] : port9_data_latch_q;
			// Driver on only for a general-purpose output pin outside forcing.
			pin_oe <= dir_next & ~sel_next & {5{~hiz_d}};
			lcd_supply_en   <= sel_next;
			pins_forced_hiz <= hiz_d;
			reg_rdata       <= rdata_d;
		end
	end

endmodule // p9gm_port
`default_nettype wire

// file: bench/p9gm_port_checker.sv
/* Checker for the five-pin port: timing of reads, writes, drivers.
   Assumes only the top module's ports and the header's offsets. */
`timescale 1ns/1ps
`default_nettype none
`include "p9gm_defines.vh"
module p9gm_port_checker(
	input wire logic core_clk, reset, reg_wr, reg_rd, reg_rmw, standby_mode,
	input wire logic pins_forced_hiz,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [4:0] pin_in, pin_out, pin_oe, lcd_supply_en);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// A plain or merged read of the data latch register.
	wire data_rd = reg_rd && reg_addr == `P9GM_OFS_DATA;
	property p_sel; (pin_oe & lcd_supply_en) == 0; endproperty
	a_sel: assert property (p_sel) else $error("driver on for lcd pin");
	property p_hiz; pins_forced_hiz |-> pin_oe == 0; endproperty
	a_hiz: assert property (p_hiz) else $error("driver on while forced");
	property p_wr; reg_wr && reg_addr == `P9GM_OFS_DATA |=> pin_out == $past(reg_wdata[4:0]);
	endproperty
	a_wr: assert property (p_wr) else $error("latch not on pins");
	property p_dir; reg_wr && reg_addr == `P9GM_OFS_DIR && !standby_mode && !pins_forced_hiz
		&& lcd_supply_en == 0 |=> pin_oe == $past(reg_wdata[4:0]); endproperty
	a_dir: assert property (p_dir) else $error("enable not from direction");
	property p_rmw; data_rd && reg_rmw |=> reg_rdata == {3'h0, $past(pin_out)}; endproperty
	a_rmw: assert property (p_rmw) else $error("merged read not latch");
	property p_out; data_rd && !reg_rmw |=> ((reg_rdata[4:0] ^ $past(pin_out)) & $past(pin_oe)) == 0;
	endproperty
	a_out: assert property (p_out) else $error("output pin read not latch");
	property p_clamp; data_rd && !reg_rmw && pins_forced_hiz
		|=> (reg_rdata[4:0] & ~$past(pin_out)) == 0; endproperty
	a_clamp: assert property (p_clamp) else $error("forced input not low");
	property p_hi; $past(reg_rd && reg_addr < 8'h02) |-> reg_rdata[7:5] == 0; endproperty
	a_hi: assert property (p_hi) else $error("unused bits not zero");
	cover property (pins_forced_hiz);
	cover property (data_rd && reg_rmw);
	cover property (lcd_supply_en == 5'h1f);
endmodule // p9gm_port_checker
bind p9gm_port p9gm_port_checker u_chk(.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rmw(reg_rmw), .standby_mode(standby_mode), .reg_addr(reg_addr),
	.pins_forced_hiz(pins_forced_hiz), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .lcd_supply_en(lcd_supply_en));
`default_nettype wire

// file: bench/p9gm_pin_model.sv
/* Pads seen from outside.
   Assumes the port's level and enable and an outside level from the bench. */
`timescale 1ns/1ps
`default_nettype none
module p9gm_pin_model(
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	input  wire logic [4:0] ext_level,
	output logic      [4:0] pin_in);
	// A driven pad shows the port's level, a released one the outside level.
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // p9gm_pin_model
`default_nettype wire

// file: bench/tb_port9_gpio_lcd_power_mux.sv
/* Bench: random and corner register traffic against the port.
   Assumes the pin model closes the pad loop. */
`timescale 1ns/1ps
`default_nettype none
`include "p9gm_defines.vh"
module tb_port9_gpio_lcd_power_mux;
	logic core_clk = 0, reset = 1, wr = 0, rd = 0, rmw = 0, sb = 0, fhiz;
	logic [7:0] a = 0, d = 0, rdata;
	logic [4:0] ext = 0, pin_in, pout, poe, lcd, lat, dir;
	int miscompares = 0, comparisons = 0, cyc = 0, seed = 73956;
	initial forever #4 core_clk = ~core_clk;
	p9gm_port u_dut(.core_clk(core_clk), .reset(reset), .reg_addr(a), .reg_wdata(d),
		.reg_wr(wr), .reg_rd(rd), .reg_rmw(rmw), .reg_rdata(rdata), .standby_mode(sb),
		.pin_in(pin_in), .pin_out(pout), .pin_oe(poe), .lcd_supply_en(lcd),
		.pins_forced_hiz(fhiz));
	p9gm_pin_model u_pins(.pin_out(pout), .pin_oe(poe), .ext_level(ext), .pin_in(pin_in));
	// Expected ordinary read: latch on outputs, outside level on inputs.
	function logic [7:0] exp_rd(input logic [4:0] l, dr, x);
		return {3'h0, (dr & l) | (~dr & x)};
	endfunction
	task chk(input logic [7:0] s, e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task w(input logic [7:0] ad, dv);
		@(posedge core_clk) begin wr <= 1; a <= ad; d <= dv; end
		@(posedge core_clk) wr <= 0;
	endtask
	task r(input logic [7:0] ad, input logic m, input logic [7:0] e);
		@(posedge core_clk) begin rd <= 1; rmw <= m; a <= ad; end
		@(posedge core_clk) begin rd <= 0; rmw <= 0; end
		#1 chk(rdata, e);
	endtask
	task print_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin miscompares++; print_verdict; end
	end
	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 0;
		r(`P9GM_OFS_DIR, 0, 8'h00);
		r(8'h07, 0, 8'h00);
		for (int i = 0; i < 40; i++) begin
			lat = 5'($random(seed));
			dir = 5'($random(seed));
			w(`P9GM_OFS_DATA, {3'h7, lat});
			w(`P9GM_OFS_DIR, {3'h7, dir});
			ext <= 5'($random(seed));
			repeat (3) @(posedge core_clk);
			chk({3'h0, poe}, {3'h0, dir});
			chk({3'h0, pout & dir}, {3'h0, lat & dir});
			r(`P9GM_OFS_DATA, 0, exp_rd(lat, dir, ext));
			r(`P9GM_OFS_DATA, 1, {3'h0, lat});
			r(`P9GM_OFS_DIR, 0, {3'h0, dir});
		end
		$display("random test done");
		w(`P9GM_OFS_DIR, 8'h00);
		w(`P9GM_OFS_CFG, 8'h1f);
		w(`P9GM_OFS_DIR, 8'h1f);
		#1 chk({3'h0, poe}, 8'h00);
		chk({3'h0, lcd}, 8'h1f);
		w(`P9GM_OFS_CFG, 8'h00);
		w(`P9GM_OFS_DIR, 8'h00);
		w(`P9GM_OFS_CFG, 8'h80);
		ext <= 5'h1f;
		sb <= 1;
		repeat (3) @(posedge core_clk);
		r(`P9GM_OFS_DATA, 0, 8'h00);
		chk({7'h0, fhiz}, 8'h01);
		sb <= 0;
		w(`P9GM_OFS_CFG, 8'h00);
		w(`P9GM_OFS_DIR, 8'h1f);
		w(`P9GM_OFS_DATA, 8'h15);
		sb <= 1;
		repeat (2) @(posedge core_clk);
		#1 chk({3'h0, poe}, 8'h1f);
		chk({3'h0, pout}, 8'h15);
		$display("corner tests done");
		print_verdict;
	end
endmodule // tb_port9_gpio_lcd_power_mux
`default_nettype wire
